//--- common/fdx_pkg.sv
// shared constants and types for the field deposit/extract shifter
package fdx_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [4:0] ADDR_SRC      = 5'h00;
  localparam logic [4:0] ADDR_CTRL     = 5'h04;
  localparam logic [4:0] ADDR_DEST     = 5'h08;
  localparam logic [4:0] ADDR_DEST_EXT = 5'h0c;
  localparam logic [4:0] ADDR_CMD      = 5'h10;
  localparam logic [4:0] ADDR_FLAGS    = 5'h14;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h18;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h1c;

  // control word fields, as seen in its fixed-point part (word bit = field bit)
  localparam int unsigned CTRL_POS_LSB = 0;
  localparam int unsigned CTRL_LEN_LSB = 6;

  // command register fields
  localparam int unsigned CMD_OP_LSB      = 0;
  localparam int unsigned CMD_IMM_BIT     = 3;
  localparam int unsigned CMD_IMM_POS_LSB = 8;
  localparam int unsigned CMD_IMM_LEN_LSB = 16;

  // flag and interrupt bit positions
  localparam int unsigned FLAG_ZERO = 0;
  localparam int unsigned FLAG_OVF  = 1;
  localparam int unsigned FLAG_SIGN = 2;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_OVF  = 1;

  localparam logic [6:0] FIX_WIDTH   = 7'h20;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    FDX_OP_DEP_SIGN    = 3'h0,
    FDX_OP_DEP_OR_SIGN = 3'h1,
    FDX_OP_EXT_ZERO    = 3'h2,
    FDX_OP_EXT_SIGN    = 3'h3,
    FDX_OP_EXPONENT    = 3'h4
  } fdx_op_e;

  typedef struct packed {
    logic sign;
    logic ovf;
    logic zero;
  } fdx_flags_s;

  typedef struct packed {
    logic [31:0] fix;
    logic [7:0]  ext;
    fdx_flags_s  flags;
  } fdx_result_s;

endpackage

//--- core/fdx_shifter.sv
// field deposit/extract and exponent shifter slice with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module fdx_shifter (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // write address channel
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [fdx_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  // write data channel
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [fdx_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // write response channel
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // read address channel
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [fdx_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  // read data channel
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [fdx_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // interrupt
  output logic                             irq
);

  // low n bits set, n saturating at the 32-bit field width
  function automatic logic [31:0] low_mask(input logic [6:0] n);
    logic [63:0] m;
    m = (64'h1 << n[5:0]) - 64'h1;
    if (n >= fdx_pkg::FIX_WIDTH) begin
      low_mask = 32'hffff_ffff;
    end else begin
      low_mask = m[31:0];
    end
  endfunction

  // merge write data under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    strb_merge = r;
  endfunction

  function automatic logic addr_known(input logic [4:0] a);
    addr_known = a inside {fdx_pkg::ADDR_SRC, fdx_pkg::ADDR_CTRL,
                           fdx_pkg::ADDR_DEST, fdx_pkg::ADDR_DEST_EXT,
                           fdx_pkg::ADDR_CMD, fdx_pkg::ADDR_FLAGS,
                           fdx_pkg::ADDR_IRQ_STAT, fdx_pkg::ADDR_IRQ_MASK};
  endfunction

  // operand and result state
  logic [31:0]         src_fix;
  logic [31:0]         ctrl_fix;
  logic [31:0]         dest_fix;
  logic [7:0]          dest_ext;
  fdx_pkg::fdx_flags_s flags;
  logic [1:0]          irq_stat;
  logic [1:0]          irq_mask;

  // write path holding registers
  logic                aw_held;
  logic                w_held;
  logic [4:0]          aw_addr_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                wr_go;
  logic                cmd_go;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held   <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held   <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held   <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fdx_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known(aw_addr_q) ? fdx_pkg::RESP_OKAY
                                            : fdx_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // command decode: writing op codes 0-4 to the command register starts one operation
  logic                imm_sel;
  logic [5:0]          op_len;
  logic [5:0]          op_pos;
  logic [2:0]          op_code;
  logic [6:0]          len_pos_sum;
  fdx_pkg::fdx_result_s res;
  logic                op_valid;

  assign cmd_go  = wr_go && (aw_addr_q == fdx_pkg::ADDR_CMD);
  assign op_code = w_data_q[fdx_pkg::CMD_OP_LSB +: 3];
  assign imm_sel = w_data_q[fdx_pkg::CMD_IMM_BIT];
  // immediate length/position only in the shift-immediate form
  assign op_len  = imm_sel ? w_data_q[fdx_pkg::CMD_IMM_LEN_LSB +: 6]
                           : ctrl_fix[fdx_pkg::CTRL_LEN_LSB +: 6];
  assign op_pos  = imm_sel ? w_data_q[fdx_pkg::CMD_IMM_POS_LSB +: 6]
                           : ctrl_fix[fdx_pkg::CTRL_POS_LSB +: 6];
  // full 6-bit range kept, so off-scale values reach the datapath
  assign len_pos_sum = {1'b0, op_len} + {1'b0, op_pos};

  always_comb begin
    logic [31:0] field;
    logic [95:0] wide_dep;
    logic [63:0] wide_ext;
    logic [6:0]  top;
    logic        sign;
    logic [5:0]  lead;
    field    = '0;
    wide_dep = '0;
    wide_ext = '0;
    top      = 7'(len_pos_sum - 7'h01);
    sign     = 1'b0;
    lead     = 6'h01;
    res      = '0;
    op_valid = 1'b1;
    case (fdx_pkg::fdx_op_e'(op_code))
      fdx_pkg::FDX_OP_DEP_SIGN, fdx_pkg::FDX_OP_DEP_OR_SIGN: begin
        field    = src_fix & low_mask({1'b0, op_len});
        // wide shift leaves zeros below the field
        wide_dep = {64'h0, field} << op_pos;
        res.fix  = wide_dep[31:0];
        if (op_len != 6'h00 && len_pos_sum <= fdx_pkg::FIX_WIDTH) begin
          sign = src_fix[5'(op_len - 6'h01)];
        end
        if (sign) begin
          res.fix = res.fix | ~low_mask(len_pos_sum);
        end
        res.ext = '0;
        if (op_code == fdx_pkg::FDX_OP_DEP_OR_SIGN) begin
          res.fix = res.fix | dest_fix;
          res.ext = dest_ext;
        end
        res.flags.ovf  = len_pos_sum > fdx_pkg::FIX_WIDTH;
        res.flags.zero = res.fix == 32'h0;
        res.flags.sign = 1'b0;
      end
      fdx_pkg::FDX_OP_EXT_ZERO, fdx_pkg::FDX_OP_EXT_SIGN: begin
        // bits beyond the left end read as zero
        wide_ext = {32'h0, src_fix} >> op_pos;
        res.fix  = wide_ext[31:0] & low_mask({1'b0, op_len});
        if (op_code == fdx_pkg::FDX_OP_EXT_SIGN &&
            op_len != 6'h00 && len_pos_sum <= fdx_pkg::FIX_WIDTH) begin
          sign = src_fix[top[4:0]];
        end
        if (sign) begin
          res.fix = res.fix | ~low_mask({1'b0, op_len});
        end
        res.ext        = '0;
        res.flags.ovf  = len_pos_sum > fdx_pkg::FIX_WIDTH;
        res.flags.zero = res.fix == 32'h0;
        res.flags.sign = 1'b0;
      end
      fdx_pkg::FDX_OP_EXPONENT: begin
        for (int i = 30; i >= 0; i--) begin
          if (src_fix[i] == src_fix[31] && lead == 6'(30 - i + 1)) begin
            lead = 6'(30 - i + 2);
          end
        end
        res.fix[7:0] = 8'(8'h00 - {2'b00, 6'(lead - 6'h01)});
        res.flags.sign = src_fix[31];
        res.flags.zero = res.fix[7:0] == 8'h00;
        res.flags.ovf  = 1'b0;
      end
      default: begin
        op_valid = 1'b0;
      end
    endcase
  end

  // register file writes and operation results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_fix  <= '0;
      ctrl_fix <= '0;
    end else if (wr_go && aw_addr_q == fdx_pkg::ADDR_SRC) begin
      src_fix  <= strb_merge(src_fix, w_data_q, w_strb_q);
    end else if (wr_go && aw_addr_q == fdx_pkg::ADDR_CTRL) begin
      ctrl_fix <= strb_merge(ctrl_fix, w_data_q, w_strb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dest_fix <= '0;
      dest_ext <= '0;
      flags    <= '0;
    end else if (cmd_go && op_valid) begin
      dest_fix <= res.fix;
      dest_ext <= res.ext;
      flags    <= res.flags;
    end else if (wr_go && aw_addr_q == fdx_pkg::ADDR_DEST) begin
      dest_fix <= strb_merge(dest_fix, w_data_q, w_strb_q);
    end else if (wr_go && aw_addr_q == fdx_pkg::ADDR_DEST_EXT &&
                 w_strb_q[0]) begin
      dest_ext <= w_data_q[7:0];
    end
  end

  // sticky events; a new event in the clearing cycle wins over the clear
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  assign irq_set[fdx_pkg::IRQ_DONE] = cmd_go && op_valid;
  assign irq_set[fdx_pkg::IRQ_OVF]  = cmd_go && op_valid && res.flags.ovf;
  assign irq_clr = (wr_go && aw_addr_q == fdx_pkg::ADDR_IRQ_STAT &&
                    w_strb_q[0]) ? w_data_q[1:0] : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= '0;
    end else if (wr_go && aw_addr_q == fdx_pkg::ADDR_IRQ_MASK &&
                 w_strb_q[0]) begin
      irq_mask <= w_data_q[1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);
  // read path, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= fdx_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= fdx_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fdx_pkg::ADDR_SRC:      s_axi_rdata <= src_fix;
        fdx_pkg::ADDR_CTRL:     s_axi_rdata <= ctrl_fix;
        fdx_pkg::ADDR_DEST:     s_axi_rdata <= dest_fix;
        fdx_pkg::ADDR_DEST_EXT: s_axi_rdata <= {24'h0, dest_ext};
        fdx_pkg::ADDR_CMD:      s_axi_rdata <= '0;
        fdx_pkg::ADDR_FLAGS:    s_axi_rdata <= {29'h0, flags};
        fdx_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
        fdx_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= fdx_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  logic dep_go;
  logic ext_go;
  logic exp_go;
  assign dep_go = cmd_go && (op_code == fdx_pkg::FDX_OP_DEP_SIGN ||
                             op_code == fdx_pkg::FDX_OP_DEP_OR_SIGN);
  assign ext_go = cmd_go && (op_code == fdx_pkg::FDX_OP_EXT_ZERO ||
                             op_code == fdx_pkg::FDX_OP_EXT_SIGN);
  assign exp_go = cmd_go && op_code == fdx_pkg::FDX_OP_EXPONENT;

  property p_ext_byte_zero;
    @(posedge aclk) disable iff (!aresetn)
      (ext_go || (cmd_go && op_code == fdx_pkg::FDX_OP_DEP_SIGN))
      |=> dest_ext == 8'h00;
  endproperty
  a_ext_byte_zero: assert property (p_ext_byte_zero)
    else $error("extension byte not cleared");
  property p_dep_ovf;
    @(posedge aclk) disable iff (!aresetn)
      dep_go |=> flags.ovf == ($past(len_pos_sum) > fdx_pkg::FIX_WIDTH);
  endproperty
  a_dep_ovf: assert property (p_dep_ovf)
    else $error("deposit overflow flag wrong");
  property p_ext_ovf;
    @(posedge aclk) disable iff (!aresetn)
      ext_go |=> flags.ovf == ($past(len_pos_sum) > fdx_pkg::FIX_WIDTH);
  endproperty
  a_ext_ovf: assert property (p_ext_ovf)
    else $error("extract overflow flag wrong");
  property p_zero_flag;
    @(posedge aclk) disable iff (!aresetn)
      (dep_go || ext_go) |=> flags.zero == (dest_fix == 32'h0) && !flags.sign;
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero or sign flag wrong after field op");
  property p_zero_fill;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_go && op_code == fdx_pkg::FDX_OP_EXT_ZERO && op_len < 6'h20)
      |=> (dest_fix >> $past(op_len)) == 32'h0;
  endproperty
  a_zero_fill: assert property (p_zero_fill)
    else $error("bits above extracted field not zero");
  property p_or_keeps;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_go && op_code == fdx_pkg::FDX_OP_DEP_OR_SIGN)
      |=> (dest_fix & $past(dest_fix)) == $past(dest_fix);
  endproperty
  a_or_keeps: assert property (p_or_keeps)
    else $error("OR deposit lost previous bits");
  property p_exp_sign;
    @(posedge aclk) disable iff (!aresetn)
      exp_go |=> flags.sign == $past(src_fix[31]) && !flags.ovf;
  endproperty
  a_exp_sign: assert property (p_exp_sign)
    else $error("exponent sign or overflow flag wrong");
  property p_exp_zero;
    @(posedge aclk) disable iff (!aresetn)
      exp_go |=> flags.zero == (dest_fix[7:0] == 8'h00) &&
                 (flags.zero == ($past(src_fix[31]) != $past(src_fix[30])));
  endproperty
  a_exp_zero: assert property (p_exp_zero)
    else $error("exponent zero flag wrong");
  property p_imm_len;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_go && !imm_sel) |-> op_len == ctrl_fix[11:6];
  endproperty
  a_imm_len: assert property (p_imm_len)
    else $error("register form did not use control length");
  c_dep_ovf: cover property (@(posedge aclk) disable iff (!aresetn)
    dep_go && len_pos_sum > fdx_pkg::FIX_WIDTH);
  c_ext_sign: cover property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && op_code == fdx_pkg::FDX_OP_EXT_SIGN && imm_sel);
  c_exp: cover property (@(posedge aclk) disable iff (!aresetn) exp_go);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule

`default_nettype wire

//--- test/fdx_shifter_test.sv
// self-checking bench for the field deposit/extract shifter
`timescale 1ns/1ps
`default_nettype none

module fdx_shifter_test;

  logic        aclk;
  logic        aresetn;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [4:0]  s_axi_awaddr;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [31:0] s_axi_wdata;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [4:0]  s_axi_araddr;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        irq;
  logic [1:0]  wr_resp;
  logic [1:0]  rd_resp;
  int          errors;
  int          total_checks;

  // boundary cases: len 0, len+pos just 32, past 32, len above 32, 63/63
  localparam logic [31:0] SRC_T [8] = '{32'h0000_3abc, 32'h1234_5678,
    32'hffff_ffff, 32'h8000_0001, 32'h0000_00ff, 32'h0000_0080,
    32'hff80_0000, 32'h0000_3abc};
  localparam logic [31:0] DST_T [8] = '{32'hf0f0_0f0f, 32'h0000_0001,
    32'h0, 32'h0000_0100, 32'h0, 32'h0, 32'h0000_0011, 32'h0};
  localparam int LEN_T [8] = '{14, 0, 8, 32, 63, 8, 9, 33};
  localparam int POS_T [8] = '{13, 5, 28, 0, 63, 24, 23, 0};
  localparam logic [31:0] EXP_T [5] = '{32'h4000_0000, 32'h0,
    32'hffff_ffff, 32'h8000_0000, 32'h0000_1000};

  fdx_shifter fdx_shifter_inst (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awprot  (3'h0),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (4'hf),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arprot  (3'h0),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .irq           (irq)
  );

  always #12.5 aclk = ~aclk;

  task automatic end_sim();
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes are judged at the falling edge so the rising edge never races
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d);
    logic ar;
    logic r;
    r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_read(a, d);
    check(d, exp);
    check({30'h0, rd_resp}, {30'h0, fdx_pkg::RESP_OKAY});
  endtask

  // unaligned addresses hit no register: error answer, no side effect
  task automatic t_bad_addr();
    logic [31:0] d;
    axi_write(5'h02, 32'hffff_ffff);
    check({30'h0, wr_resp}, {30'h0, fdx_pkg::RESP_SLVERR});
    axi_read(5'h06, d);
    check({30'h0, rd_resp}, {30'h0, fdx_pkg::RESP_SLVERR});
    check(d, 32'h0);
    rd_chk(fdx_pkg::ADDR_SRC, 32'h0);
    axi_write(fdx_pkg::ADDR_IRQ_MASK, 32'h0);
    check({30'h0, wr_resp}, {30'h0, fdx_pkg::RESP_OKAY});
  endtask

  task automatic irq_chk(input logic e);
    @(negedge aclk);
    check({31'h0, irq}, {31'h0, e});
  endtask

  // reference: fixed part and flags {sign, overflow, zero}
  function automatic void model(input logic [2:0] op, input logic [31:0] s,
      input logic [31:0] d, input int l, input int p,
      output logic [31:0] r, output logic [2:0] f);
    logic [63:0] v;
    logic [63:0] m;
    logic        top;
    int          w;
    int          n;
    w = (l > 32) ? 32 : l;
    m = (64'h1 << w) - 64'h1;
    if (op >= 3'h2) v = ({32'h0, s} >> p) & m;
    else v = ({32'h0, s} & m) << p;
    top = (w > 0) && (l + p <= 32) &&
          v[(op >= 3'h2) ? w - 1 : l + p - 1];
    if (top && op != 3'h2)
      v = v | ~((64'h1 << ((op == 3'h3) ? w : l + p)) - 64'h1);
    r = v[31:0];
    if (op == 3'h1) r = r | d;
    f = {1'b0, (l + p > 32), (r == 32'h0)};
    if (op == 3'h4) begin
      n = 1;
      while (n < 32 && s[31 - n] == s[31]) n++;
      r = {24'h0, 8'(1 - n)};
      f = {s[31], 1'b0, (n == 1)};
    end
  endfunction

  task automatic run_op(input logic [2:0] op, input logic [31:0] s,
      input logic [31:0] d, input int l, input int p, input logic imm);
    logic [31:0] r;
    logic [2:0]  f;
    logic [5:0]  dl;
    logic [5:0]  dp;
    model(op, s, d, l, p, r, f);
    // decoy values in the unused source of length/position
    dl = 6'(l) ^ 6'h2b;
    dp = 6'(p) ^ 6'h11;
    axi_write(fdx_pkg::ADDR_IRQ_STAT, 32'h3);
    axi_write(fdx_pkg::ADDR_SRC, s);
    axi_write(fdx_pkg::ADDR_DEST, d);
    axi_write(fdx_pkg::ADDR_DEST_EXT, 32'h5a);
    axi_write(fdx_pkg::ADDR_CTRL, imm ? {20'h0, dl, dp} :
              {20'h0, 6'(l), 6'(p)});
    axi_write(fdx_pkg::ADDR_CMD, imm ?
              {10'h0, 6'(l), 2'h0, 6'(p), 4'h0, 1'b1, op} :
              {10'h0, dl, 2'h0, dp, 4'h0, 1'b0, op});
    rd_chk(fdx_pkg::ADDR_DEST, r);
    rd_chk(fdx_pkg::ADDR_DEST_EXT, (op == 3'h1) ? 32'h5a : 32'h0);
    rd_chk(fdx_pkg::ADDR_FLAGS, {29'h0, f});
    rd_chk(fdx_pkg::ADDR_IRQ_STAT, {30'h0, f[1], 1'b1});
  endtask

  task automatic t_reset();
    for (int a = 0; a < 32; a += 4) rd_chk(5'(a), 32'h0);
    irq_chk(1'b0);
  endtask

  task automatic t_fields(input logic [2:0] op);
    for (int i = 0; i < 8; i++)
      run_op(op, SRC_T[i], DST_T[i], LEN_T[i], POS_T[i], i[0]);
  endtask

  task automatic t_exponent();
    for (int i = 0; i < 5; i++)
      run_op(3'h4, EXP_T[i], 32'hffff_ffff, 0, 0, 1'b0);
  endtask

  // unused op codes and read-only flags leave state untouched
  task automatic t_idle_ops();
    run_op(3'h0, SRC_T[2], DST_T[2], LEN_T[2], POS_T[2], 1'b0);
    for (int c = 5; c < 8; c++) axi_write(fdx_pkg::ADDR_CMD, 32'(c));
    axi_write(fdx_pkg::ADDR_FLAGS, 32'h7);
    rd_chk(fdx_pkg::ADDR_FLAGS, 32'h2);
    rd_chk(fdx_pkg::ADDR_IRQ_STAT, 32'h3);
    rd_chk(fdx_pkg::ADDR_CMD, 32'h0);
  endtask

  task automatic t_irq();
    axi_write(fdx_pkg::ADDR_IRQ_MASK, 32'h0);
    run_op(3'h2, SRC_T[0], DST_T[0], LEN_T[0], POS_T[0], 1'b1);
    irq_chk(1'b0);
    axi_write(fdx_pkg::ADDR_IRQ_MASK, 32'h1);
    irq_chk(1'b1);
    rd_chk(fdx_pkg::ADDR_IRQ_MASK, 32'h1);
    axi_write(fdx_pkg::ADDR_IRQ_STAT, 32'h1);
    rd_chk(fdx_pkg::ADDR_IRQ_STAT, 32'h0);
    irq_chk(1'b0);
    axi_write(fdx_pkg::ADDR_IRQ_MASK, 32'h2);
    run_op(3'h3, SRC_T[2], DST_T[2], LEN_T[2], POS_T[2], 1'b0);
    irq_chk(1'b1);
    axi_write(fdx_pkg::ADDR_IRQ_STAT, 32'h2);
    rd_chk(fdx_pkg::ADDR_IRQ_STAT, 32'h1);
    irq_chk(1'b0);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 5'h0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 5'h0;
    s_axi_rready = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bad_addr();
    t_fields(3'h0);
    t_fields(3'h1);
    t_fields(3'h2);
    t_fields(3'h3);
    t_exponent();
    t_idle_ops();
    t_irq();
    end_sim();
  end

  // the whole sequence needs about fifteen hundred cycles
  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    end_sim();
  end

endmodule

`default_nettype wire
